// File: logic/gsc_pkg.sv
// Contract
// - Suspend field selects off, 2Hz, 1Hz, 0.5Hz
// - Suspend default from NV 31h bits 7:6
// - Address read opcode 33h or 39h
// - Undervoltage sleep needs both enables set
// - Alarm routed to data line or pin
// - Alarm only with enable and suspend off
// - Offset blanking follows its enable bit
// - Timing select applies only after recall
// - Copy busy flag blocks NV writes
// - Lock needs arm bit; cleared after lock
// - Three read-only block lock flags
// - Power-up flag set on reset, write zero
// - Alarm enable write one, bus reset clears
// - Snapshot flag set, host writes zero
// - Net address family, serial, CRC layout
package gsc_pkg;
   localparam logic [7:0] GSC_ADDR_STATUS   = 8'h01;
   localparam logic [7:0] GSC_ADDR_NVLOCK   = 8'h07;
   localparam logic [7:0] GSC_ADDR_FEATURE  = 8'h08;
   localparam logic [7:0] GSC_ADDR_NV_DEF   = 8'h31;
   localparam logic [7:0] GSC_NV_BASE       = 8'h20;
   localparam logic [7:0] GSC_NV_END        = 8'h7F;
   localparam logic [7:0] GSC_OPC_ADDR_A    = 8'h33;
   localparam logic [7:0] GSC_OPC_ADDR_B    = 8'h39;
   localparam logic [7:0] GSC_NV_DEF_RESET  = 8'h00;
   localparam logic [7:0] GSC_FAMILY        = 8'h5A; // Arbitrary value
   localparam logic [47:0] GSC_SERIAL       = 48'h0000_0000_0001; // Arbitrary value
   // Status bit positions
   localparam int GSC_SP_HI  = 7;
   localparam int GSC_SP_LO  = 6;
   localparam int GSC_PSE    = 5;
   localparam int GSC_OPS    = 4;
   localparam int GSC_UVS    = 3;
   localparam int GSC_AOS    = 2;
   localparam int GSC_OBE    = 1;
   localparam int GSC_FTS    = 0;
   // Lock register bit positions
   localparam int GSC_CIP    = 7;
   localparam int GSC_ARM    = 6;
   // Feature register bit positions
   localparam int GSC_PUP    = 7;
   localparam int GSC_PIN    = 6;
   localparam int GSC_AIE    = 2;
   localparam int GSC_SNP    = 0;
   localparam logic [7:0] GSC_NVLOCK_MASK  = 8'hC7;
   localparam logic [7:0] GSC_FEATURE_MASK = 8'hC5;
   localparam logic [7:0] GSC_FEATURE_RESET = 8'h80;
   // Suspend periods in ms, and the ms tick divider
   localparam int GSC_SUS_MS_01 = 500;
   localparam int GSC_SUS_MS_10 = 1000;
   localparam int GSC_SUS_MS_11 = 2000;
   localparam int GSC_CLK_MHZ   = 100;
   localparam int GSC_MS_CYC    = GSC_CLK_MHZ * 1000;
   typedef enum logic [1:0] {
      GSC_ACTIVE  = 2'b00,
      GSC_SUSPEND = 2'b01,
      GSC_SLEEP   = 2'b11
   } gsc_pmode_t;
endpackage

// File: logic/gsc_tick_if.sv
`timescale 1ns/1ps
interface gsc_tick_if;
   logic        run;
   logic [1:0]  period;
   logic        wake;
   modport src (output run, output period, input wake);
   modport tmr (input run, input period, output wake);
endinterface

// File: logic/gsc_sus_timer.sv
`timescale 1ns/1ps
module gsc_sus_timer #(
   parameter int MS_CYC = gsc_pkg::GSC_MS_CYC
) (
   // Clock and reset
   input  wire logic   ref_clk,
   input  wire logic   rstn,
   // Control
   gsc_tick_if.tmr     tk
);
   logic [31:0] cyc;
   logic [31:0] next_cyc;
   logic [11:0] ms;
   logic [11:0] next_ms;
   logic [11:0] lim;
   logic        next_wake;
   logic        wake_q;

   always_comb begin
      case (tk.period)
         2'b01:   lim = 12'(gsc_pkg::GSC_SUS_MS_01 - 1);
         2'b10:   lim = 12'(gsc_pkg::GSC_SUS_MS_10 - 1);
         default: lim = 12'(gsc_pkg::GSC_SUS_MS_11 - 1);
      endcase
   end

   // Millisecond divider then period count
   always_comb begin
      next_cyc  = cyc;
      next_ms   = ms;
      next_wake = 1'b0;
      if (!tk.run) begin
         next_cyc = '0;
         next_ms  = '0;
      end else if (cyc == 32'(MS_CYC - 1)) begin
         next_cyc = '0;
         if (ms >= lim) begin
            next_ms   = '0;
            next_wake = 1'b1;
         end else begin
            next_ms = ms + 12'h001;
         end
      end else begin
         next_cyc = cyc + 32'h0000_0001;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cyc    <= '0;
         ms     <= '0;
         wake_q <= 1'b0;
      end else begin
         cyc    <= next_cyc;
         ms     <= next_ms;
         wake_q <= next_wake;
      end
   end

   assign tk.wake = wake_q;
endmodule // gsc_sus_timer

// File: logic/gsc_regs.sv
`timescale 1ns/1ps
module gsc_regs #(
   parameter int MS_CYC = gsc_pkg::GSC_MS_CYC
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // Byte access from the serial engine
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   output logic [7:0]       reg_rdata,
   input  wire logic        bus_reset,
   // Nonvolatile block events
   input  wire logic        nv_recall0,
   input  wire logic        copy_start,
   input  wire logic        copy_done,
   input  wire logic        lock_cmd,
   input  wire logic [1:0]  lock_block,
   output logic             nv_wr_allow,
   // Measurement and pins
   input  wire logic        snapshot_done,
   input  wire logic        undervolt,
   input  wire logic        idle_low,
   input  wire logic        alarm_hit,
   input  wire logic        pin_in,
   // Configuration outputs
   output logic [7:0]       addr_opcode,
   output logic             fast_timing,
   output logic             offset_blank,
   output logic             alarm_on_data,
   output logic             alarm_on_pin,
   output logic             hold_snapshot,
   output logic [63:0]      net_addr,
   output gsc_pkg::gsc_pmode_t pmode
);
   logic [7:0] nv_def;
   logic [7:0] next_nv_def;
   logic [7:0] status;
   logic [7:0] next_status;
   logic [7:0] nvlock;
   logic [7:0] next_nvlock;
   logic [7:0] feat;
   logic [7:0] next_feat;
   logic       pin_s1;
   logic       pin_s2;
   logic       por_load;
   logic       ao_d;
   logic       ao_p;
   gsc_pkg::gsc_pmode_t next_pmode;
   gsc_tick_if tk ();

   // --------------------------------------------------------------
   // Pin synchroniser
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
      end else begin
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
      end
   end

   function automatic logic in_nv(input logic [7:0] a);
      in_nv = (a >= gsc_pkg::GSC_NV_BASE) && (a <= gsc_pkg::GSC_NV_END);
   endfunction

   function automatic logic blk_locked(input logic [7:0] a, input logic [7:0] l);
      logic [1:0] b;
      b = 2'(8'(a - gsc_pkg::GSC_NV_BASE) >> 5);
      blk_locked = l[b];
   endfunction

   // --------------------------------------------------------------
   // Register next values
   // --------------------------------------------------------------
   always_comb begin
      next_nv_def = nv_def;
      next_status = status;
      next_nvlock = nvlock;
      next_feat   = feat;
      // Shadow of default byte, guarded by copy and lock state
      if (reg_wr && (reg_addr == gsc_pkg::GSC_ADDR_NV_DEF) && !nvlock[gsc_pkg::GSC_CIP]
          && !blk_locked(reg_addr, nvlock)) begin
         next_nv_def = reg_wdata;
      end
      // Status loads only from recall, incl. power-up recall
      if (por_load || nv_recall0) begin
         next_status = nv_def;
      end
      // Copy busy flag
      if (copy_start) begin
         next_nvlock[gsc_pkg::GSC_CIP] = 1'b1;
      end else if (copy_done) begin
         next_nvlock[gsc_pkg::GSC_CIP] = 1'b0;
      end
      if (reg_wr && reg_addr == gsc_pkg::GSC_ADDR_NVLOCK && reg_wdata[gsc_pkg::GSC_ARM]) begin
         next_nvlock[gsc_pkg::GSC_ARM] = 1'b1;
      end
      if (lock_cmd && nvlock[gsc_pkg::GSC_ARM] && lock_block <= 2'd2) begin
         next_nvlock[lock_block]       = 1'b1;
         next_nvlock[gsc_pkg::GSC_ARM] = 1'b0;
      end
      // Feature register: write-zero and write-one bits, plus directly written PIN bit
      if (reg_wr && reg_addr == gsc_pkg::GSC_ADDR_FEATURE) begin
         if (!reg_wdata[gsc_pkg::GSC_PUP]) begin
            next_feat[gsc_pkg::GSC_PUP] = 1'b0;
         end
         next_feat[gsc_pkg::GSC_PIN] = reg_wdata[gsc_pkg::GSC_PIN];
         if (reg_wdata[gsc_pkg::GSC_AIE]) begin
            next_feat[gsc_pkg::GSC_AIE] = 1'b1;
         end
         if (!reg_wdata[gsc_pkg::GSC_SNP]) begin
            next_feat[gsc_pkg::GSC_SNP] = 1'b0;
         end
      end
      if (bus_reset) begin
         next_feat[gsc_pkg::GSC_AIE] = 1'b0;
      end
      if (snapshot_done) begin
         next_feat[gsc_pkg::GSC_SNP] = 1'b1;
      end
      if (pmode == gsc_pkg::GSC_SUSPEND) begin
         next_feat[gsc_pkg::GSC_PIN] = 1'b0;
      end
      next_nvlock = next_nvlock & gsc_pkg::GSC_NVLOCK_MASK;
      next_feat   = next_feat & gsc_pkg::GSC_FEATURE_MASK;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         nv_def   <= gsc_pkg::GSC_NV_DEF_RESET;
         status   <= gsc_pkg::GSC_NV_DEF_RESET;
         nvlock   <= 8'h00;
         feat     <= gsc_pkg::GSC_FEATURE_RESET;
         por_load <= 1'b1;
      end else begin
         nv_def   <= next_nv_def;
         status   <= next_status;
         nvlock   <= next_nvlock;
         feat     <= next_feat;
         por_load <= 1'b0;
      end
   end

   // --------------------------------------------------------------
   // Power mode
   // --------------------------------------------------------------
   assign tk.run    = (pmode == gsc_pkg::GSC_SUSPEND);
   assign tk.period = status[gsc_pkg::GSC_SP_HI:gsc_pkg::GSC_SP_LO];

   always_comb begin
      next_pmode = pmode;
      case (pmode)
         gsc_pkg::GSC_ACTIVE: begin
            if (status[gsc_pkg::GSC_PSE]) begin
               if (undervolt && status[gsc_pkg::GSC_UVS]) begin
                  next_pmode = gsc_pkg::GSC_SLEEP;
               end else if (idle_low && tk.period != 2'b00) begin
                  next_pmode = gsc_pkg::GSC_SUSPEND;
               end else if (idle_low) begin
                  next_pmode = gsc_pkg::GSC_SLEEP;
               end
            end
         end
         gsc_pkg::GSC_SUSPEND: begin
            if (!idle_low || tk.wake || !status[gsc_pkg::GSC_PSE]) begin
               next_pmode = gsc_pkg::GSC_ACTIVE;
            end
         end
         gsc_pkg::GSC_SLEEP: begin
            // Undervoltage sleep holds while the cell stays low
            if (!status[gsc_pkg::GSC_PSE]
                || (!idle_low && !(undervolt && status[gsc_pkg::GSC_UVS]))) begin
               next_pmode = gsc_pkg::GSC_ACTIVE;
            end
         end
         default: next_pmode = gsc_pkg::GSC_ACTIVE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pmode <= gsc_pkg::GSC_ACTIVE;
      end else begin
         pmode <= next_pmode;
      end
   end

   gsc_sus_timer #(.MS_CYC(MS_CYC)) u_tmr (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .tk      (tk)
   );

   // --------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------
   assign ao_d = alarm_hit && feat[gsc_pkg::GSC_AIE] && (tk.period == 2'b00)
                 && status[gsc_pkg::GSC_AOS];
   assign ao_p = alarm_hit && feat[gsc_pkg::GSC_AIE] && (tk.period == 2'b00)
                 && !status[gsc_pkg::GSC_AOS];

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata     <= 8'h00;
         addr_opcode   <= gsc_pkg::GSC_OPC_ADDR_A;
         fast_timing   <= 1'b0;
         offset_blank  <= 1'b0;
         alarm_on_data <= 1'b0;
         alarm_on_pin  <= 1'b0;
         hold_snapshot <= 1'b0;
         nv_wr_allow   <= 1'b0;
      end else begin
         case (reg_addr)
            gsc_pkg::GSC_ADDR_STATUS:  reg_rdata <= status;
            gsc_pkg::GSC_ADDR_NVLOCK:  reg_rdata <= nvlock;
            gsc_pkg::GSC_ADDR_FEATURE: reg_rdata <= {feat[7], pin_s2, feat[5:0]};
            gsc_pkg::GSC_ADDR_NV_DEF:  reg_rdata <= nv_def;
            default:                   reg_rdata <= 8'h00;
         endcase
         addr_opcode   <= status[gsc_pkg::GSC_OPS] ? gsc_pkg::GSC_OPC_ADDR_B
                                                   : gsc_pkg::GSC_OPC_ADDR_A;
         fast_timing   <= status[gsc_pkg::GSC_FTS];
         offset_blank  <= status[gsc_pkg::GSC_OBE];
         alarm_on_data <= ao_d;
         alarm_on_pin  <= ao_p;
         hold_snapshot <= feat[gsc_pkg::GSC_SNP];
         nv_wr_allow   <= in_nv(reg_addr) && !nvlock[gsc_pkg::GSC_CIP]
                          && !blk_locked(reg_addr, nvlock);
      end
   end

   assign net_addr = {gsc_crc8({gsc_pkg::GSC_SERIAL, gsc_pkg::GSC_FAMILY}),
                      gsc_pkg::GSC_SERIAL, gsc_pkg::GSC_FAMILY};

   // Reflected x^8+x^5+x^4+1 over 56 bits, LSB first
   function automatic logic [7:0] gsc_crc8(input logic [55:0] d);
      logic [7:0] c;
      logic       fb;
      c = 8'h00;
      for (int i = 0; i < 56; i++) begin
         fb = c[0] ^ d[i];
         c  = {fb, c[7:1]} ^ (fb ? 8'h0C : 8'h00);
      end
      gsc_crc8 = c;
   endfunction

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   sequence s_arm_lock;
      nvlock[gsc_pkg::GSC_ARM] && lock_cmd && lock_block != 2'd3;
   endsequence

   chk_status_recall: assert property (@(posedge ref_clk) disable iff (!rstn)
      nv_recall0 |=> status == $past(nv_def)) else $error("status not recalled");
   chk_opcode_sel: assert property (@(posedge ref_clk) disable iff (!rstn)
      ##1 addr_opcode == ($past(status[gsc_pkg::GSC_OPS]) ? gsc_pkg::GSC_OPC_ADDR_B : gsc_pkg::GSC_OPC_ADDR_A))
      else $error("bad opcode");
   chk_uv_sleep: assert property (@(posedge ref_clk) disable iff (!rstn)
      next_pmode == gsc_pkg::GSC_SLEEP && pmode == gsc_pkg::GSC_ACTIVE |-> status[gsc_pkg::GSC_PSE])
      else $error("sleep without power saving");
   chk_uv_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
      pmode == gsc_pkg::GSC_ACTIVE && undervolt && !idle_low && !(status[gsc_pkg::GSC_UVS]
      && status[gsc_pkg::GSC_PSE]) |=> pmode == gsc_pkg::GSC_ACTIVE) else $error("uv sleep gate");
   chk_alarm_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
      alarm_on_data || alarm_on_pin |-> $past(feat[gsc_pkg::GSC_AIE]) && $past(tk.period) == 2'b00)
      else $error("alarm not gated");
   chk_copy_block: assert property (@(posedge ref_clk) disable iff (!rstn)
      reg_wr && reg_addr == gsc_pkg::GSC_ADDR_NV_DEF && nvlock[gsc_pkg::GSC_CIP] |=> $stable(nv_def))
      else $error("write during copy");
   chk_lock_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_arm_lock |=> !nvlock[gsc_pkg::GSC_ARM] && nvlock[$past(lock_block)])
      else $error("lock did not complete");
   chk_snapshot_valid_set: assert property (@(posedge ref_clk) disable iff (!rstn)
      snapshot_done |=> feat[gsc_pkg::GSC_SNP] ##1 hold_snapshot) else $error("snapshot flag");
   chk_ie_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
      bus_reset |=> !feat[gsc_pkg::GSC_AIE]) else $error("alarm enable kept");
endmodule // gsc_regs

// File: verification/gsc_host_model.sv
`timescale 1ns/1ps
// ------------------------------------
// Host side byte access model
// ------------------------------------
module gsc_host_model (
   // Clock
   input  wire logic        ref_clk,
   // Byte access
   output logic [7:0]       reg_addr,
   output logic [7:0]       reg_wdata,
   output logic             reg_wr,
   input  wire logic [7:0]  reg_rdata,
   // Observed results
   output logic [63:0]      obs_data,
   output logic             obs_vld
);
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      obs_data  = 64'h0;
      obs_vld   = 1'b0;
   end

   // Whole bytes only; config via 31h then recall, arm, flag clears
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #1 reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask

   task automatic point(input logic [7:0] a);
      @(posedge ref_clk);
      #1 reg_addr = a;
      @(posedge ref_clk);
      #1;
   endtask

   task automatic show(input logic [63:0] v);
      obs_data = v;
      obs_vld = 1'b1;
      @(posedge ref_clk);
      #1 obs_vld = 1'b0;
      @(posedge ref_clk);
      #1;
   endtask

   task automatic rd(input logic [7:0] a);
      point(a);
      show({56'h0, reg_rdata});
   endtask
endmodule // gsc_host_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic ref_clk, rstn, bus_reset, nv_recall0, copy_start, copy_done;
   logic lock_cmd, snapshot_done, undervolt, idle_low, alarm_hit, pin_in;
   logic nv_wr_allow, fast_timing, offset_blank, alarm_on_data, alarm_on_pin;
   logic hold_snapshot, reg_wr, obs_vld;
   logic [1:0]  lock_block;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, addr_opcode, v;
   logic [31:0] r;
   logic [63:0] net_addr, obs_data;
   logic [63:0] exp_q[$];
   gsc_pkg::gsc_pmode_t pmode;
   int          err_total;
   int          cmp_count;
   int          n;
   localparam int MS = 10;

   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;

   gsc_regs #(.MS_CYC(MS)) dut_u (
      .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .bus_reset,
      .nv_recall0, .copy_start, .copy_done, .lock_cmd, .lock_block, .nv_wr_allow,
      .snapshot_done, .undervolt, .idle_low, .alarm_hit, .pin_in, .addr_opcode,
      .fast_timing, .offset_blank, .alarm_on_data, .alarm_on_pin, .hold_snapshot,
      .net_addr, .pmode
   );
   gsc_host_model host_u (
      .ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .obs_data, .obs_vld
   );

   // ------------------------------------
   // Scoreboard
   // ------------------------------------
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   always @(posedge ref_clk) begin
      if (obs_vld === 1'b1 && exp_q.size() > 0) begin
         chk(obs_data, exp_q.pop_front());
      end
   end

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({56'h0, e});
      host_u.rd(a);
   endtask

   task automatic see(input logic [63:0] s, input logic [63:0] e);
      exp_q.push_back(e);
      host_u.show(s);
   endtask

   task automatic pulse(ref logic s);
      @(posedge ref_clk);
      #1 s = 1'b1;
      @(posedge ref_clk);
      #1 s = 1'b0;
   endtask

   task automatic cfg(input logic [7:0] d);
      host_u.wr(8'h31, d);
      pulse(nv_recall0);
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   function automatic logic [7:0] crc8(input logic [55:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int k = 0; k < 56; k++) begin
         c = (c[0] ^ d[k]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
      end
      return c;
   endfunction

   task automatic end_sim();
      if (exp_q.size() != 0) begin
         err_total++;
      end
      if (err_total == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #500000;
      err_total++;
      end_sim();
   end

   // ------------------------------------
   // Main sequence
   // ------------------------------------
   initial begin
      {rstn, bus_reset, nv_recall0, copy_start, copy_done, lock_cmd} = 6'h00;
      {snapshot_done, undervolt, idle_low, alarm_hit, pin_in} = 5'h00;
      lock_block = 2'd0;
      err_total = 0;
      cmp_count = 0;
      void'($urandom(2950));
      repeat (2) @(posedge ref_clk);
      #1 rstn = 1'b1;
      @(posedge ref_clk);
      rd(8'h01, 8'h00);
      see(64'(addr_opcode), 64'(gsc_pkg::GSC_OPC_ADDR_A));
      rd(8'h08, 8'h80);
      host_u.wr(8'h08, 8'hBE);
      rd(8'h08, 8'h84);
      host_u.wr(8'h08, 8'h00);
      rd(8'h08, 8'h04);
      pulse(snapshot_done);
      rd(8'h08, 8'h05);
      see(64'(hold_snapshot), 64'h1);
      host_u.wr(8'h08, 8'h04);
      rd(8'h08, 8'h04);
      rd(8'h05, 8'h00);
      host_u.wr(8'h01, 8'hFF);
      rd(8'h01, 8'h00);
      alarm_hit = 1'b1;
      for (int i = 0; i < 5; i++) begin
         r = $urandom;
         v = {i[1:0], r[5:3], i[2], r[1:0]};
         cfg(v);
         rd(8'h01, v);
         see(64'({addr_opcode, fast_timing, offset_blank}),
             64'({v[4] ? gsc_pkg::GSC_OPC_ADDR_B : gsc_pkg::GSC_OPC_ADDR_A, v[0], v[1]}));
         see(64'({alarm_on_data, alarm_on_pin}),
             64'({v[7:6] == 2'b00 && v[2], v[7:6] == 2'b00 && !v[2]}));
      end
      pulse(bus_reset);
      rd(8'h08, 8'h00);
      see(64'({alarm_on_data, alarm_on_pin}), 64'h0);
      alarm_hit = 1'b0;
      undervolt = 1'b1;
      cfg(8'h08);
      see(64'(pmode), 64'(gsc_pkg::GSC_ACTIVE));
      cfg(8'h28);
      see(64'(pmode), 64'(gsc_pkg::GSC_SLEEP));
      undervolt = 1'b0;
      cfg(8'h60);
      idle_low = 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1 n++;
      end while (pmode == gsc_pkg::GSC_SUSPEND && n < 6000);
      see(64'(n > gsc_pkg::GSC_SUS_MS_01 * MS && n <= gsc_pkg::GSC_SUS_MS_01 * MS + 3), 64'h1);
      idle_low = 1'b0;
      cfg(8'h28);
      pulse(copy_start);
      rd(8'h07, 8'h80);
      host_u.point(8'h40);
      see(64'(nv_wr_allow), 64'h0);
      host_u.wr(8'h31, 8'h55);
      rd(8'h31, 8'h28);
      pulse(copy_done);
      host_u.point(8'h40);
      see(64'(nv_wr_allow), 64'h1);
      lock_block = 2'd1;
      pulse(lock_cmd);
      rd(8'h07, 8'h00);
      host_u.wr(8'h07, 8'hFF);
      rd(8'h07, 8'h40);
      lock_block = 2'd0;
      pulse(lock_cmd);
      rd(8'h07, 8'h01);
      host_u.point(8'h20);
      see(64'(nv_wr_allow), 64'h0);
      host_u.point(8'h7F);
      see(64'(nv_wr_allow), 64'h1);
      host_u.wr(8'h31, 8'hAA);
      rd(8'h31, 8'h28);
      host_u.wr(8'h07, 8'h40);
      lock_block = 2'd2;
      pulse(lock_cmd);
      rd(8'h07, 8'h05);
      host_u.point(8'h7F);
      see(64'(nv_wr_allow), 64'h0);
      see(net_addr, {crc8({gsc_pkg::GSC_SERIAL, gsc_pkg::GSC_FAMILY}),
                     gsc_pkg::GSC_SERIAL, gsc_pkg::GSC_FAMILY});
      pin_in = r[7];
      repeat (2) @(posedge ref_clk);
      rd(8'h08, {1'b0, r[7], 6'h00});
      #1 rstn = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 rstn = 1'b1;
      @(posedge ref_clk);
      rd(8'h08, {1'b1, r[7], 6'h00});
      see(64'(addr_opcode), 64'(gsc_pkg::GSC_OPC_ADDR_A));
      repeat (3) @(posedge ref_clk);
      end_sim();
   end
endmodule // tb_top
